// *** hw/evt_pack_pkg.sv ***
// Shared constants, word layouts and state types for the event word packer
package evt_pack_pkg;
	// Register byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_SWEEP  = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_MASK   = 8'h0C;
	localparam logic [7:0] A_FORMAT = 8'h10;
	localparam logic [7:0] A_DROP   = 8'h14;
	// Control bit positions
	localparam int CTRL_EN     = 0;
	localparam int CTRL_TAG    = 8;
	localparam int CTRL_NOSWP  = 12;
	localparam int CTRL_NEEDLOST = 16;
	// Status and mask bits
	localparam int ST_W    = 3;
	localparam int ST_DONE = 0;
	localparam int ST_OOR  = 1;
	localparam int ST_LOST = 2;
	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] SWEEP_RST = 32'h0000_0FC0;
	// Time field widths per format
	localparam int TB_T0 = 12;
	localparam int TB_T5 = 20;
	localparam int TB_T1 = 28;
	localparam int TB_T3 = 54;
	localparam int SHORT_MARGIN = 64;
	localparam logic [31:0] SHORT_MAX = 32'((1 << TB_T0) - SHORT_MARGIN);
	localparam logic [31:0] T5_MAX    = 32'(1 << TB_T5);
	localparam logic [31:0] T1_MAX    = 32'(1 << TB_T1);
	// Byte counts per word
	localparam logic [3:0] NB_2 = 4'h2;
	localparam logic [3:0] NB_4 = 4'h4;
	localparam logic [3:0] NB_8 = 4'h8;
	// Format codes as read back by software
	localparam logic [7:0] FC_T0  = 8'h00;
	localparam logic [7:0] FC_T5  = 8'h05;
	localparam logic [7:0] FC_T1  = 8'h01;
	localparam logic [7:0] FC_T5B = 8'h5B;
	localparam logic [7:0] FC_T3  = 8'h03;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [3:0] NB_ONE = 4'h1;

	typedef enum logic [2:0] {FMT_T0, FMT_T5, FMT_T1, FMT_T5B, FMT_T3} fmt_e;

	typedef struct packed {
		logic        lost;
		logic [15:0] tag;
		logic [15:0] sweep;
		logic [TB_T3-1:0] offset;
		logic        falling;
		logic [2:0]  chan;
	} evt_s;

	typedef struct packed {logic falling; logic [2:0] chan;} head_s;
	typedef struct packed {logic [TB_T0-1:0] t; head_s h;} w_t0_s;
	typedef struct packed {logic [7:0] swp; logic [TB_T5-1:0] t; head_s h;} w_t5_s;
	typedef struct packed {logic [TB_T1-1:0] t; head_s h;} w_t1_s;
	typedef struct packed {
		logic lost; logic [14:0] tag; logic [15:0] swp; logic [TB_T1-1:0] t; head_s h;
	} w_t5b_s;
	typedef struct packed {logic lost; logic [4:0] tag; logic [TB_T3-1:0] t; head_s h;} w_t3_s;

	typedef struct packed {
		logic [31:0]     ctrl;
		logic [31:0]     sweep;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [15:0]     drop;
		logic            irq;
		logic            a_valid;
		logic            a_write;
		logic [7:0]      a_addr;
		logic            rd_wait;
		logic [31:0]     hrdata;
		logic            hreadyout;
		logic            hresp;
	} pk_st_s;

	typedef struct packed {
		logic [63:0] sh;
		logic [3:0]  left;
		logic        valid;
		logic        last;
		logic        rdy;
	} ser_st_s;
endpackage

// *** hw/word_serializer.sv ***
// Byte serializer that sends a loaded word low byte first
`timescale 1ns/10ps
module word_serializer (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        accept_en,
	input  wire logic        load,
	input  wire logic [63:0] word,
	input  wire logic [3:0]  nbytes,
	input  wire logic        byte_ready,
	output logic             rdy,
	output logic             byte_valid,
	output logic [7:0]       byte_data,
	output logic             byte_last,
	output logic             done
);
	evt_pack_pkg::ser_st_s s_ff;
	evt_pack_pkg::ser_st_s nxt_s;
	logic                  pop;

	always_comb begin
		nxt_s = s_ff;
		pop = s_ff.valid && byte_ready;
		if (pop) begin
			nxt_s.sh = {8'h00, s_ff.sh[63:8]};
			nxt_s.left = s_ff.left - evt_pack_pkg::NB_ONE;
			nxt_s.valid = (s_ff.left != evt_pack_pkg::NB_ONE);
			nxt_s.last = (s_ff.left == evt_pack_pkg::NB_2);
		end
		if (load) begin
			nxt_s.sh = word;
			nxt_s.left = nbytes;
			nxt_s.valid = 1'b1;
			nxt_s.last = (nbytes == evt_pack_pkg::NB_ONE);
		end
		nxt_s.rdy = accept_en && !nxt_s.valid;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rdy        = s_ff.rdy;
	assign byte_valid = s_ff.valid;
	assign byte_data  = s_ff.sh[7:0];
	assign byte_last  = s_ff.last;
	assign done       = pop && (s_ff.left == evt_pack_pkg::NB_ONE);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_lsb_first;
		pop && !s_ff.last |=> byte_data == $past(s_ff.sh[15:8]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("byte order broken");
endmodule // word_serializer

// *** hw/tdc_event_word_packer.sv ***
// Event word packer with AHB-Lite registers and byte stream output
`timescale 1ns/10ps
module tdc_event_word_packer (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	input  wire logic                evt_valid,
	input  wire evt_pack_pkg::evt_s  evt,
	output logic                     evt_ready,
	output logic                     byte_valid,
	output logic [7:0]               byte_data,
	output logic                     byte_last,
	input  wire logic                byte_ready,
	output logic                     irq
);
	localparam int ST_BITS = evt_pack_pkg::ST_W;

	evt_pack_pkg::pk_st_s st_ff;
	evt_pack_pkg::pk_st_s nxt_st;
	evt_pack_pkg::fmt_e   fmt;
	evt_pack_pkg::w_t0_s  w0;
	evt_pack_pkg::w_t5_s  w5;
	evt_pack_pkg::w_t1_s  w1;
	evt_pack_pkg::w_t5b_s w5b;
	evt_pack_pkg::w_t3_s  w3;
	evt_pack_pkg::head_s  head;
	logic [63:0]          word;
	logic [3:0]           nbytes;
	logic [7:0]           fcode;
	logic                 oor;
	logic                 has_lost;
	logic                 take;
	logic                 load;
	logic                 done;
	logic                 tag_en;
	logic                 no_swp;
	logic                 need_lost;
	logic [ST_BITS-1:0]   set_bits;
	logic [ST_BITS-1:0]   clr_bits;
	logic [31:0]          rd_mux;

	assign tag_en    = st_ff.ctrl[evt_pack_pkg::CTRL_TAG];
	assign no_swp    = st_ff.ctrl[evt_pack_pkg::CTRL_NOSWP];
	assign need_lost = st_ff.ctrl[evt_pack_pkg::CTRL_NEEDLOST];

	// Format selection
	always_comb begin
		if (need_lost || tag_en) begin
			fmt = no_swp ? evt_pack_pkg::FMT_T3 : evt_pack_pkg::FMT_T5B;
		end else if (no_swp) begin
			if (st_ff.sweep <= evt_pack_pkg::SHORT_MAX) begin
				fmt = evt_pack_pkg::FMT_T0;
			end else if (st_ff.sweep <= evt_pack_pkg::T1_MAX) begin
				fmt = evt_pack_pkg::FMT_T1;
			end else begin
				fmt = evt_pack_pkg::FMT_T3;
			end
		end else begin
			fmt = (st_ff.sweep <= evt_pack_pkg::T5_MAX) ? evt_pack_pkg::FMT_T5 : evt_pack_pkg::FMT_T5B;
		end
	end

	// Word packing
	always_comb begin
		head = '{falling: evt.falling, chan: evt.chan};
		w0 = '{t: evt.offset[evt_pack_pkg::TB_T0-1:0], h: head};
		w5 = '{swp: evt.sweep[7:0], t: evt.offset[evt_pack_pkg::TB_T5-1:0], h: head};
		w1 = '{t: evt.offset[evt_pack_pkg::TB_T1-1:0], h: head};
		w5b = '{lost: evt.lost,
			tag: tag_en ? evt.tag[14:0] : 15'h0000,
			swp: evt.sweep,
			t: evt.offset[evt_pack_pkg::TB_T1-1:0],
			h: head};
		w3 = '{lost: evt.lost,
			tag: tag_en ? evt.tag[4:0] : 5'h00,
			t: evt.offset,
			h: head};
		word = 64'h0000_0000_0000_0000;
		nbytes = evt_pack_pkg::NB_2;
		fcode = evt_pack_pkg::FC_T0;
		oor = 1'b0;
		has_lost = 1'b0;
		unique case (fmt)
			evt_pack_pkg::FMT_T0: begin
				word = 64'(w0);
				nbytes = evt_pack_pkg::NB_2;
				fcode = evt_pack_pkg::FC_T0;
				oor = |(evt.offset >> evt_pack_pkg::TB_T0);
				has_lost = 1'b0;
			end
			evt_pack_pkg::FMT_T5: begin
				word = 64'(w5);
				nbytes = evt_pack_pkg::NB_4;
				fcode = evt_pack_pkg::FC_T5;
				oor = |(evt.offset >> evt_pack_pkg::TB_T5);
				has_lost = 1'b0;
			end
			evt_pack_pkg::FMT_T1: begin
				word = 64'(w1);
				nbytes = evt_pack_pkg::NB_4;
				fcode = evt_pack_pkg::FC_T1;
				oor = |(evt.offset >> evt_pack_pkg::TB_T1);
				has_lost = 1'b0;
			end
			evt_pack_pkg::FMT_T5B: begin
				word = 64'(w5b);
				nbytes = evt_pack_pkg::NB_8;
				fcode = evt_pack_pkg::FC_T5B;
				oor = |(evt.offset >> evt_pack_pkg::TB_T1);
				has_lost = 1'b1;
			end
			evt_pack_pkg::FMT_T3: begin
				word = 64'(w3);
				nbytes = evt_pack_pkg::NB_8;
				fcode = evt_pack_pkg::FC_T3;
				oor = 1'b0;
				has_lost = 1'b1;
			end
		endcase
	end

	// One event per cycle at most, and only while the serializer is free
	assign take = evt_valid && evt_ready;
	assign load = take && !oor;

	word_serializer u_ser (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.accept_en  (st_ff.ctrl[evt_pack_pkg::CTRL_EN]),
		.load       (load),
		.word       (word),
		.nbytes     (nbytes),
		.byte_ready (byte_ready),
		.rdy        (evt_ready),
		.byte_valid (byte_valid),
		.byte_data  (byte_data),
		.byte_last  (byte_last),
		.done       (done)
	);

	// Register read mux
	always_comb begin
		unique case (st_ff.a_addr)
			evt_pack_pkg::A_CTRL:   rd_mux = st_ff.ctrl;
			evt_pack_pkg::A_SWEEP:  rd_mux = st_ff.sweep;
			evt_pack_pkg::A_STATUS: rd_mux = 32'(st_ff.status);
			evt_pack_pkg::A_MASK:   rd_mux = 32'(st_ff.mask);
			evt_pack_pkg::A_FORMAT: rd_mux = {20'h00000, nbytes, fcode};
			evt_pack_pkg::A_DROP:   rd_mux = 32'(st_ff.drop);
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus slave, status and interrupt
	always_comb begin
		nxt_st = st_ff;
		set_bits = '0;
		clr_bits = '0;
		set_bits[evt_pack_pkg::ST_DONE] = done;
		set_bits[evt_pack_pkg::ST_OOR] = take && oor;
		set_bits[evt_pack_pkg::ST_LOST] = load && has_lost && evt.lost;
		if (take && oor) begin
			nxt_st.drop = st_ff.drop + 16'h0001;
		end
		if (st_ff.a_valid && st_ff.a_write) begin
			unique case (st_ff.a_addr)
				evt_pack_pkg::A_CTRL:   nxt_st.ctrl = hwdata;
				evt_pack_pkg::A_SWEEP:  nxt_st.sweep = hwdata;
				evt_pack_pkg::A_STATUS: clr_bits = hwdata[ST_BITS-1:0];
				evt_pack_pkg::A_MASK:   nxt_st.mask = hwdata[ST_BITS-1:0];
				default: ;
			endcase
			nxt_st.a_valid = 1'b0;
		end
		nxt_st.status = (st_ff.status & ~clr_bits) | set_bits;
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
		if (st_ff.rd_wait) begin
			nxt_st.hrdata = rd_mux;
			nxt_st.hreadyout = 1'b1;
			nxt_st.rd_wait = 1'b0;
			nxt_st.a_valid = 1'b0;
		end else if (hready) begin
			if (hsel && htrans[1] && hsize == evt_pack_pkg::HSIZE_WORD) begin
				nxt_st.a_valid = 1'b1;
				nxt_st.a_write = hwrite;
				nxt_st.a_addr = haddr[7:0];
				nxt_st.rd_wait = !hwrite;
				nxt_st.hreadyout = hwrite;
			end else begin
				nxt_st.a_valid = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.ctrl <= evt_pack_pkg::CTRL_RST;
			st_ff.sweep <= evt_pack_pkg::SWEEP_RST;
			st_ff.hreadyout <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = st_ff.hreadyout;
	assign hresp     = st_ff.hresp;
	assign hrdata    = st_ff.hrdata;
	assign irq       = st_ff.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_chan;
		load |=> byte_valid && byte_data[2:0] == $past(evt.chan);
	endproperty
	a_chan: assert property (p_chan) else $error("channel not in low bits");

	property p_edge;
		load |=> byte_data[3] == $past(evt.falling);
	endproperty
	a_edge: assert property (p_edge) else $error("edge bit wrong");

	property p_lost;
		load && has_lost |-> word[63] == evt.lost;
	endproperty
	a_lost: assert property (p_lost) else $error("lost flag wrong");

	property p_len;
		load |-> nbytes == evt_pack_pkg::NB_2 || nbytes == evt_pack_pkg::NB_4
			|| nbytes == evt_pack_pkg::NB_8;
	endproperty
	a_len: assert property (p_len) else $error("bad word length");

	property p_fmt5;
		load && fmt == evt_pack_pkg::FMT_T5 |-> nbytes == evt_pack_pkg::NB_4
			&& word[31:24] == evt.sweep[7:0] && word[23:4] == evt.offset[19:0];
	endproperty
	a_fmt5: assert property (p_fmt5) else $error("format 5 layout wrong");

	property p_fmt5b;
		load && fmt == evt_pack_pkg::FMT_T5B |-> nbytes == evt_pack_pkg::NB_8
			&& word[47:32] == evt.sweep && word[62:48] == (tag_en ? evt.tag[14:0] : 15'h0000);
	endproperty
	a_fmt5b: assert property (p_fmt5b) else $error("format 5b layout wrong");

	property p_fmt3;
		load && fmt == evt_pack_pkg::FMT_T3 |-> word[57:4] == evt.offset
			&& word[62:58] == (tag_en ? evt.tag[4:0] : 5'h00);
	endproperty
	a_fmt3: assert property (p_fmt3) else $error("format 3 layout wrong");

	property p_short;
		fmt == evt_pack_pkg::FMT_T0 |-> st_ff.sweep <= 32'h0000_0FC0 && no_swp && !tag_en;
	endproperty
	a_short: assert property (p_short) else $error("short format misused");

	property p_noswp;
		no_swp |-> fmt != evt_pack_pkg::FMT_T5 && fmt != evt_pack_pkg::FMT_T5B;
	endproperty
	a_noswp: assert property (p_noswp) else $error("sweep counter kept");

	property p_drop;
		take && oor |=> st_ff.drop == $past(st_ff.drop) + 16'h0001 && !byte_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("overflowing event not dropped");

	property p_irq;
		##1 (st_ff.status & st_ff.mask) != '0 |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_fmt0;
		load && fmt == evt_pack_pkg::FMT_T0 |-> nbytes == evt_pack_pkg::NB_2
			&& word[63:16] == 48'h0000_0000_0000 && word[15:4] == evt.offset[11:0];
	endproperty
	a_fmt0: assert property (p_fmt0) else $error("short word layout wrong");

	property p_offset;
		load && fmt == evt_pack_pkg::FMT_T1 |-> nbytes == evt_pack_pkg::NB_4
			&& word[63:32] == 32'h0000_0000 && word[31:4] == evt.offset[27:0];
	endproperty
	a_offset: assert property (p_offset) else $error("time offset misplaced");

	property p_select;
		need_lost |-> fmt == evt_pack_pkg::FMT_T5B || fmt == evt_pack_pkg::FMT_T3;
	endproperty
	a_select: assert property (p_select) else $error("format lacks lost flag");

	property p_one_evt;
		load |=> !evt_ready;
	endproperty
	a_one_evt: assert property (p_one_evt) else $error("event taken while busy");

	property p_notag;
		load && !tag_en && has_lost |-> word[62:58] == 5'h00;
	endproperty
	a_notag: assert property (p_notag) else $error("tag bits without tag enable");

	property p_lost_flag;
		load && has_lost && evt.lost |=> st_ff.status[evt_pack_pkg::ST_LOST];
	endproperty
	a_lost_flag: assert property (p_lost_flag) else $error("lost status not set");

	property p_oor_flag;
		take && oor |=> st_ff.status[evt_pack_pkg::ST_OOR];
	endproperty
	a_oor_flag: assert property (p_oor_flag) else $error("range status not set");

	property p_read;
		st_ff.rd_wait |=> hreadyout && !hresp;
	endproperty
	a_read: assert property (p_read) else $error("read data phase not ended");

	property p_hold;
		byte_valid && !byte_ready |=> byte_valid && $stable(byte_data);
	endproperty
	a_hold: assert property (p_hold) else $error("byte dropped before accepted");

	c_short: cover property (load && fmt == evt_pack_pkg::FMT_T0);
	c_drop: cover property (take && oor);
	c_read: cover property (st_ff.rd_wait ##1 hreadyout);
	c_long: cover property (load && nbytes == evt_pack_pkg::NB_8);
	c_lost: cover property (load && has_lost && evt.lost);
endmodule // tdc_event_word_packer

// *** bench/host_sink.sv ***
// Host-side byte sink that rebuilds event words with random stalls
`timescale 1ns/10ps
module host_sink (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	input  wire logic       byte_last,
	output logic            byte_ready
);
	logic [63:0] words[$];
	logic [3:0]  nbs[$];
	logic [63:0] acc = 64'h0;
	logic [3:0]  cnt = 4'h0;
	int          seed = 32'h465af5c4;
	always @(posedge core_clk) begin
		byte_ready <= rst_n && (($random(seed) & 3) != 0);
		if (rst_n && byte_valid && byte_ready) begin
			acc = acc | (64'(byte_data) << (8 * cnt));
			cnt = cnt + 4'h1;
			if (byte_last) begin
				words.push_back(acc);
				nbs.push_back(cnt);
				acc = 64'h0;
				cnt = 4'h0;
			end
		end
	end
endmodule // host_sink

// *** bench/tdc_event_word_packer_test.sv ***
// Self-checking bench for the event word packer
`timescale 1ns/10ps
module tdc_event_word_packer_test;
	logic                core_clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                hsel = 1'b0;
	logic [31:0]         haddr = 32'h0;
	logic [1:0]          htrans = 2'h0;
	logic                hwrite = 1'b0;
	logic [2:0]          hsize = 3'h0;
	logic [31:0]         hwdata = 32'h0;
	logic                hready;
	logic                hresp;
	logic [31:0]         hrdata;
	logic                evt_valid = 1'b0;
	evt_pack_pkg::evt_s  evt = '0;
	logic                evt_ready;
	logic                byte_valid;
	logic [7:0]          byte_data;
	logic                byte_last;
	logic                byte_ready;
	logic                irq;
	int                  seed = 32'h465af5c4;
	int                  error_cnt = 0;
	int                  samples_checked = 0;
	int                  drops = 0;
	logic [31:0]         rd;
	logic [63:0]         expq[$];
	evt_pack_pkg::fmt_e  f;
	evt_pack_pkg::evt_s  e;
	logic [53:0]         m;
	localparam int TBW[5] = '{12, 20, 28, 28, 54};
	localparam logic [3:0] NBY[5] = '{4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
	localparam logic [7:0] FCD[5] = '{8'h00, 8'h05, 8'h01, 8'h5B, 8'h03};
	localparam logic [31:0] CF[8] = '{32'h1001, 32'h1001, 32'h1, 32'h1, 32'h1101, 32'h101,
		32'h10001, 32'h1001};
	localparam logic [31:0] SW[8] = '{32'hFC0, 32'hFC1, 32'h100000, 32'h100001, 32'h10, 32'h64,
		32'h10, 32'h10000001};

	always #5 core_clk = ~core_clk;

	tdc_event_word_packer i_tdc_event_word_packer (
		.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .evt_valid(evt_valid), .evt(evt), .evt_ready(evt_ready),
		.byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last),
		.byte_ready(byte_ready), .irq(irq)
	);

	host_sink i_host_sink (
		.core_clk(core_clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
		.byte_last(byte_last), .byte_ready(byte_ready)
	);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= evt_pack_pkg::HSIZE_WORD;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
		chk(64'(hresp), 64'h0);
	endtask

	task automatic send(input evt_pack_pkg::evt_s ev);
		@(posedge core_clk);
		evt_valid <= 1'b1;
		evt <= ev;
		do @(posedge core_clk); while (evt_ready !== 1'b1);
		evt_valid <= 1'b0;
	endtask

	function automatic evt_pack_pkg::fmt_e pick(logic [31:0] c, logic [31:0] s);
		if (c[evt_pack_pkg::CTRL_TAG] || c[evt_pack_pkg::CTRL_NEEDLOST])
			return c[evt_pack_pkg::CTRL_NOSWP] ? evt_pack_pkg::FMT_T3 : evt_pack_pkg::FMT_T5B;
		if (c[evt_pack_pkg::CTRL_NOSWP])
			return s <= 32'd4032 ? evt_pack_pkg::FMT_T0 :
				(s <= 32'h1000_0000 ? evt_pack_pkg::FMT_T1 : evt_pack_pkg::FMT_T3);
		return s <= 32'h0010_0000 ? evt_pack_pkg::FMT_T5 : evt_pack_pkg::FMT_T5B;
	endfunction

	function automatic logic [63:0] exp_word(evt_pack_pkg::fmt_e fm, evt_pack_pkg::evt_s v,
		logic tg);
		logic [15:0] t;
		t = tg ? v.tag : 16'h0;
		case (fm)
			evt_pack_pkg::FMT_T0: return {48'h0, v.offset[11:0], v.falling, v.chan};
			evt_pack_pkg::FMT_T5: return {32'h0, v.sweep[7:0], v.offset[19:0], v.falling, v.chan};
			evt_pack_pkg::FMT_T1: return {32'h0, v.offset[27:0], v.falling, v.chan};
			evt_pack_pkg::FMT_T5B: return {v.lost, t[14:0], v.sweep, v.offset[27:0], v.falling, v.chan};
			default: return {v.lost, t[4:0], v.offset, v.falling, v.chan};
		endcase
	endfunction

	function automatic evt_pack_pkg::evt_s rnd();
		logic [127:0] r;
		evt_pack_pkg::evt_s v;
		r = {$random(seed), $random(seed), $random(seed), $random(seed)};
		v = r[$bits(evt_pack_pkg::evt_s)-1:0];
		v.chan = 3'(1 + ($unsigned($random(seed)) % 6));
		return v;
	endfunction

	initial begin
		#300000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(1'b0, evt_pack_pkg::A_CTRL, 32'h0);
		chk(64'(rd), 64'(evt_pack_pkg::CTRL_RST));
		bus(1'b0, evt_pack_pkg::A_SWEEP, 32'h0);
		chk(64'(rd), 64'(evt_pack_pkg::SWEEP_RST));
		bus(1'b1, 8'h18, 32'hFFFF_FFFF);
		bus(1'b0, 8'h18, 32'h0);
		chk(64'(rd), 64'h0);
		bus(1'b1, evt_pack_pkg::A_MASK, 32'h2);
		for (int k = 0; k < 8; k++) begin
			f = pick(CF[k], SW[k]);
			m = (54'h1 << TBW[f]) - 54'h1;
			bus(1'b1, evt_pack_pkg::A_SWEEP, SW[k]);
			bus(1'b1, evt_pack_pkg::A_CTRL, CF[k]);
			bus(1'b0, evt_pack_pkg::A_FORMAT, 32'h0);
			chk(64'(rd[11:0]), 64'({NBY[f], FCD[f]}));
			for (int i = 0; i < 8; i++) begin
				e = rnd();
				e.offset = (i == 6) ? m : ((i == 7) ? m + 54'h1 : e.offset & m);
				e.lost = (i == 6) ? 1'b1 : e.lost;
				if (e.offset <= m)
					expq.push_back(exp_word(f, e, CF[k][evt_pack_pkg::CTRL_TAG]));
				else
					drops++;
				send(e);
			end
			for (int n = 0; n < 600 && i_host_sink.words.size() < expq.size(); n++)
				@(posedge core_clk);
			chk(64'(i_host_sink.words.size()), 64'(expq.size()));
			while (expq.size() > 0) begin
				chk(i_host_sink.words.pop_front(), expq.pop_front());
				chk(64'(i_host_sink.nbs.pop_front()), 64'(NBY[f]));
			end
			bus(1'b0, evt_pack_pkg::A_DROP, 32'h0);
			chk(64'(rd), 64'(drops[15:0]));
			$display("config %0d done", k);
		end
		bus(1'b0, evt_pack_pkg::A_STATUS, 32'h0);
		chk(64'(rd[2:0]), 64'h7);
		chk(64'(irq), 64'h1);
		bus(1'b1, evt_pack_pkg::A_STATUS, 32'h2);
		repeat (2) @(posedge core_clk);
		chk(64'(irq), 64'h0);
		bus(1'b0, evt_pack_pkg::A_STATUS, 32'h0);
		chk(64'(rd[2:0]), 64'h5);
		bus(1'b1, evt_pack_pkg::A_MASK, 32'h1);
		repeat (2) @(posedge core_clk);
		chk(64'(irq), 64'h1);
		$display("interrupt test done");
		report_and_stop();
	end
endmodule // tdc_event_word_packer_test
